//--- core/sssc_core.sv
// Program flow core: return stack, paging, skips and logic operations.
`timescale 1ns/1ps
`default_nettype none
`include "sssc_params.svh"

////////////////////////////////////////////////////////////////////////
module sssc_core
	import sssc_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int RAM_AW = 8
)(
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	////////////////////////////////////////////////////////////////////
	function automatic logic isMapped(input logic [5:0] idx);
		isMapped = idx inside {`SSSC_IDX_PCL, `SSSC_IDX_STATUS,
			`SSSC_IDX_INDPTR, `SSSC_IDX_ISSUE, `SSSC_IDX_WREG,
			`SSSC_IDX_PCFULL, `SSSC_IDX_RTC, `SSSC_IDX_FLAGS};
	endfunction : isMapped

	function automatic logic [7:0] effAddr(input logic [11:0] ins,
		input logic [7:0] ptr);
		logic [4:0] f;
		f = ins[4:0];
		if (f == 5'h00)
			effAddr = ptr;
		else if (f[4])
			effAddr = {ptr[7:5], f};
		else
			effAddr = {3'h0, f};
	endfunction : effAddr

	function automatic logic [7:0] logicOp(input logic [1:0] sel,
		input logic [7:0] a, input logic [7:0] b);
		unique case (sel)
			2'h0: logicOp = b;
			2'h1: logicOp = a | b;
			2'h2: logicOp = a & b;
			2'h3: logicOp = a ^ b;
		endcase
	endfunction : logicOp

	////////////////////////////////////////////////////////////////////
	sssc_state_t state;
	logic [10:0] pc;
	logic [10:0] pcNext;
	logic [7:0]  status;
	logic [7:0]  indPtr;
	logic [7:0]  wReg;
	logic [7:0]  rtc;
	logic [11:0] instrReg;
	logic        skipPending;
	logic        badPageFlag;
	logic [7:0]  skipCount;
	logic [10:0] stackTop;
	logic [7:0]  ramRd;
	logic [7:0]  fa;
	logic [7:0]  opnd;
	logic        execNow;

	logic [7:0]  aluRes;
	logic        toW;
	logic        toF;
	logic        zUpd;
	logic        cUpd;
	logic        cNew;
	logic        skipCond;
	logic        doPush;
	logic        doPop;
	logic        pcLoad;
	logic [10:0] pcVal;
	logic        pageLoad;
	logic [2:0]  pageVal;
	logic        bankLoad;
	logic        rtcAdd;
	logic        badPage;

	logic [ADDR_W-1:0] awAddr;
	logic        awHeld;
	logic [31:0] wData;
	logic [3:0]  wStrb;
	logic        wHeld;
	logic        doWrite;
	logic [5:0]  wrIdx;
	logic        lane0;
	logic        wrIssue;
	logic        discardNow;
	logic [31:0] rdWord;

	assign pcNext     = pc + 11'h001;
	assign execNow    = (state == ST_EXEC);
	assign fa         = effAddr(instrReg, indPtr);
	assign doWrite    = awHeld & wHeld & ~s_axi_bvalid & (state == ST_IDLE);
	assign wrIdx      = awAddr[7:2];
	assign lane0      = doWrite & wStrb[0];
	assign wrIssue    = doWrite & (wrIdx == `SSSC_IDX_ISSUE);
	assign discardNow = wrIssue & skipPending;

	////////////////////////////////////////////////////////////////////
	// Option, watchdog and mode registers have no file address here.
	always_comb
	begin
		if (fa == `SSSC_FA_PCL)
			opnd = pc[7:0];
		else if (fa == `SSSC_FA_STATUS)
			opnd = status;
		else if (fa == `SSSC_FA_INDPTR)
			opnd = indPtr;
		else
			opnd = ramRd;
	end

	always_comb
	begin
		aluRes   = 8'h00;
		toW      = 1'b0;
		toF      = 1'b0;
		zUpd     = 1'b0;
		cUpd     = 1'b0;
		cNew     = status[`SSSC_ST_C];
		skipCond = 1'b0;
		doPush   = 1'b0;
		doPop    = 1'b0;
		pcLoad   = 1'b0;
		pcVal    = stackTop;
		pageLoad = 1'b0;
		pageVal  = instrReg[2:0];
		bankLoad = 1'b0;
		rtcAdd   = 1'b0;
		badPage  = 1'b0;
		casez (instrReg)
			`SSSC_OP_LOGIC:
			begin
				if (instrReg[7:6] != 2'h3)
				begin
					aluRes = logicOp(instrReg[7:6] + 2'h1, wReg, opnd);
					toF    = instrReg[5];
					toW    = ~instrReg[5];
					zUpd   = 1'b1;
				end
			end
			`SSSC_OP_NOT_F:
			begin
				aluRes = ~opnd;
				toF    = 1'b1;
				zUpd   = 1'b1;
			end
			`SSSC_OP_ROT:
			begin
				if (instrReg[6])
				begin
					aluRes = {opnd[6:0], status[`SSSC_ST_C]};
					cNew   = opnd[7];
				end
				else
				begin
					aluRes = {status[`SSSC_ST_C], opnd[7:1]};
					cNew   = opnd[0];
				end
				toF  = 1'b1;
				cUpd = 1'b1;
			end
			`SSSC_OP_SWAP:
			begin
				aluRes = {opnd[3:0], opnd[7:4]};
				toF    = instrReg[5];
				toW    = ~instrReg[5];
			end
			`SSSC_OP_SKIPZ:
			begin
				aluRes   = instrReg[8] ? opnd + 8'h01 : opnd - 8'h01;
				toF      = 1'b1;
				skipCond = (aluRes == 8'h00);
			end
			`SSSC_OP_SKIPB:
			begin
				skipCond = opnd[instrReg[7:5]] == instrReg[8];
			end
			`SSSC_OP_LIT:
			begin
				// The XOR form (bits 9:8 = 3) with literal FF complements the working register.
				aluRes = logicOp(instrReg[9:8], wReg, instrReg[7:0]);
				toW    = 1'b1;
				zUpd   = 1'b1;
			end
			`SSSC_OP_RETLIT:
			begin
				aluRes = instrReg[7:0];
				toW    = 1'b1;
				doPop  = 1'b1;
				pcLoad = 1'b1;
			end
			`SSSC_OP_CALL:
			begin
				doPush = 1'b1;
				pcLoad = 1'b1;
				pcVal  = {status[6:5], 1'b0, instrReg[7:0]};
			end
			`SSSC_OP_JMP:
			begin
				pcLoad = 1'b1;
				pcVal  = {status[6:5], instrReg[8:0]};
			end
			`SSSC_OP_RETURN:
			begin
				doPop    = 1'b1;
				pcLoad   = 1'b1;
				pageLoad = (instrReg[1:0] == 2'h1);
				pageVal  = {1'b0, stackTop[10:9]};
				rtcAdd   = (instrReg[1:0] == 2'h3);
			end
			`SSSC_OP_PAGE:
			begin
				badPage  = (instrReg[2:0] > `SSSC_PAGE_MAX);
				pageLoad = ~badPage;
			end
			`SSSC_OP_BANK:
			begin
				bankLoad = 1'b1;
			end
			default:
			begin
				aluRes = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			state <= ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE: if (wrIssue && !skipPending) state <= ST_READ;
				ST_READ: state <= ST_EXEC;
				ST_EXEC: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			instrReg <= 12'h000;
		else if (wrIssue)
			instrReg <= wData[11:0];
	end

	// A skipped page or bank slot leaves the skip armed for the next one.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			skipPending <= 1'b0;
			skipCount   <= 8'h00;
		end
		else if (discardNow)
		begin
			skipPending <= (wData[11:0] ==? `SSSC_OP_PAGE) ||
				(wData[11:0] ==? `SSSC_OP_BANK);
			skipCount   <= skipCount + 8'h01;
		end
		else if (execNow)
			skipPending <= skipCond;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			pc <= 11'h000;
		else if (discardNow)
			pc <= pcNext;
		else if (lane0 && wrIdx == `SSSC_IDX_PCL)
			pc <= {status[6:5], 1'b0, wData[7:0]};
		else if (execNow)
		begin
			if (pcLoad)
				pc <= pcVal;
			else if (toF && fa == `SSSC_FA_PCL)
				pc <= {status[6:5], 1'b0, aluRes};
			else
				pc <= pcNext;
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			status <= `SSSC_STATUS_RST;
		else if (lane0 && wrIdx == `SSSC_IDX_STATUS)
			status <= (status & ~`SSSC_STATUS_WMSK) |
				(wData[7:0] & `SSSC_STATUS_WMSK);
		else if (execNow)
		begin
			if (toF && fa == `SSSC_FA_STATUS)
				status <= (status & ~`SSSC_STATUS_WMSK) |
					(aluRes & `SSSC_STATUS_WMSK);
			if (zUpd)
				status[`SSSC_ST_Z] <= (aluRes == 8'h00);
			if (cUpd)
				status[`SSSC_ST_C] <= cNew;
			if (pageLoad)
				status[`SSSC_ST_PA_HI:`SSSC_ST_PA_LO] <= pageVal;
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			indPtr <= 8'h00;
		else if (lane0 && wrIdx == `SSSC_IDX_INDPTR)
			indPtr <= wData[7:0];
		else if (execNow && bankLoad)
			indPtr[7:5] <= instrReg[2:0];
		else if (execNow && toF && fa == `SSSC_FA_INDPTR)
			indPtr <= aluRes;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			wReg <= 8'h00;
		else if (lane0 && wrIdx == `SSSC_IDX_WREG)
			wReg <= wData[7:0];
		else if (execNow && toW)
			wReg <= aluRes;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			rtc <= 8'h00;
		else if (lane0 && wrIdx == `SSSC_IDX_RTC)
			rtc <= wData[7:0];
		else if (execNow && rtcAdd)
			rtc <= rtc + wReg;
	end

	// A new bad page event in the clearing cycle keeps the flag set.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			badPageFlag <= 1'b0;
		else if (execNow && badPage)
			badPageFlag <= 1'b1;
		else if (lane0 && wrIdx == `SSSC_IDX_FLAGS && wData[0])
			badPageFlag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	sssc_return_stack
	#(
		.DEPTH (8),
		.WIDTH (11)
	) u_stack (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.push     (execNow & doPush),
		.pop      (execNow & doPop),
		.pushData (pcNext),
		.top      (stackTop)
	);

	sssc_file_ram
	#(
		.ADDR_W (RAM_AW)
	) u_ram (
		.clk_sys (clk_sys),
		.wrEn    (execNow & toF & ~(fa inside {`SSSC_FA_PCL,
			`SSSC_FA_STATUS, `SSSC_FA_INDPTR})),
		.wrAddr  (fa[RAM_AW-1:0]),
		.wrData  (aluRes),
		.rdAddr  (fa[RAM_AW-1:0]),
		.rdData  (ramRd)
	);

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			awHeld        <= 1'b0;
			awAddr        <= '0;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			awHeld        <= 1'b1;
			awAddr        <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else if (doWrite)
		begin
			awHeld        <= 1'b0;
			s_axi_awready <= 1'b1;
		end
		else
			s_axi_awready <= ~awHeld;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			wHeld        <= 1'b0;
			wData        <= 32'h0000_0000;
			wStrb        <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			wHeld        <= 1'b1;
			wData        <= s_axi_wdata;
			wStrb        <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		else if (doWrite)
		begin
			wHeld        <= 1'b0;
			s_axi_wready <= 1'b1;
		end
		else
			s_axi_wready <= ~wHeld;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SSSC_RESP_OKAY;
		end
		else if (doWrite)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= isMapped(wrIdx) ? `SSSC_RESP_OKAY :
				`SSSC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_comb
	begin
		unique case (s_axi_araddr[7:2])
			`SSSC_IDX_PCL:    rdWord = {24'h0, pc[7:0]};
			`SSSC_IDX_STATUS: rdWord = {24'h0, status};
			`SSSC_IDX_INDPTR: rdWord = {24'h0, indPtr};
			`SSSC_IDX_ISSUE:  rdWord = {20'h0, instrReg};
			`SSSC_IDX_WREG:   rdWord = {24'h0, wReg};
			`SSSC_IDX_PCFULL: rdWord = {5'h0, stackTop, 5'h0, pc};
			`SSSC_IDX_RTC:    rdWord = {24'h0, rtc};
			`SSSC_IDX_FLAGS:  rdWord = {16'h0, skipCount, 5'h0,
				state != ST_IDLE, skipPending, badPageFlag};
			default:          rdWord = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SSSC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdWord;
			s_axi_rresp   <= isMapped(s_axi_araddr[7:2]) ?
				`SSSC_RESP_OKAY : `SSSC_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
		else
			s_axi_arready <= ~s_axi_rvalid;
	end

endmodule : sssc_core

`default_nettype wire

//--- inc/sssc_params.svh
// Constants for the subroutine stack and skip control block.
`ifndef SSSC_PARAMS_SVH
`define SSSC_PARAMS_SVH

// Register indices; the bus byte address is four times the index.
`define SSSC_IDX_PCL     6'h02
`define SSSC_IDX_STATUS  6'h03
`define SSSC_IDX_INDPTR  6'h04
`define SSSC_IDX_ISSUE   6'h10
`define SSSC_IDX_WREG    6'h11
`define SSSC_IDX_PCFULL  6'h12
`define SSSC_IDX_RTC     6'h13
`define SSSC_IDX_FLAGS   6'h14

// File register addresses.
`define SSSC_FA_PCL      8'h02
`define SSSC_FA_STATUS   8'h03
`define SSSC_FA_INDPTR   8'h04

// Status bit positions, reset value and software-writable mask.
`define SSSC_ST_C        0
`define SSSC_ST_DIGC     1
`define SSSC_ST_Z        2
`define SSSC_ST_PWDN     3
`define SSSC_ST_WDOG     4
`define SSSC_ST_PA_LO    5
`define SSSC_ST_PA_HI    7
`define SSSC_STATUS_RST  8'h18
`define SSSC_STATUS_WMSK 8'hE7
`define SSSC_PAGE_MAX    3'h3

`define SSSC_RESP_OKAY   2'h0
`define SSSC_RESP_SLVERR 2'h2

// Opcode patterns of the instructions this block executes.
`define SSSC_OP_LOGIC    12'b0001_????_????
`define SSSC_OP_NOT_F    12'b0010_011?_????
`define SSSC_OP_ROT      12'b0011_0?1?_????
`define SSSC_OP_SWAP     12'b0011_10??_????
`define SSSC_OP_SKIPZ    12'b001?_111?_????
`define SSSC_OP_SKIPB    12'b011?_????_????
`define SSSC_OP_LIT      12'b11??_????_????
`define SSSC_OP_RETLIT   12'b1000_????_????
`define SSSC_OP_CALL     12'b1001_????_????
`define SSSC_OP_JMP      12'b101?_????_????
`define SSSC_OP_RETURN   12'b0000_0000_11??
`define SSSC_OP_PAGE     12'b0000_0001_0???
`define SSSC_OP_BANK     12'b0000_0001_1???

`endif

//--- inc/sssc_pkg.sv
// Types shared by the subroutine stack and skip control block.
package sssc_pkg;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_EXEC = 3'b100
	} sssc_state_t;

endpackage : sssc_pkg

//--- core/sssc_return_stack.sv
// Eight-level push/pop return address stack.
`timescale 1ns/1ps
`default_nettype none

module sssc_return_stack
#(
	parameter int DEPTH = 8,
	parameter int WIDTH = 11
)(
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] pushData,
	output logic      [WIDTH-1:0] top
);

	logic [WIDTH-1:0] level [DEPTH];

	// There is no depth counter, so overflow and underflow are silent.
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < DEPTH; i++)
				level[i] <= '0;
		end
		else if (push)
		begin
			level[0] <= pushData;
			for (int i = 1; i < DEPTH; i++)
				level[i] <= level[i-1];
		end
		else if (pop)
		begin
			// The deepest level keeps its value and is duplicated.
			for (int i = 0; i < DEPTH - 1; i++)
				level[i] <= level[i+1];
		end
	end

	assign top = level[0];

endmodule : sssc_return_stack

`default_nettype wire

//--- core/sssc_file_ram.sv
// General purpose file register storage with a registered read port.
`timescale 1ns/1ps
`default_nettype none

module sssc_file_ram
#(
	parameter int ADDR_W = 8
)(
	input  wire logic              clk_sys,
	input  wire logic              wrEn,
	input  wire logic [ADDR_W-1:0] wrAddr,
	input  wire logic [7:0]        wrData,
	input  wire logic [ADDR_W-1:0] rdAddr,
	output logic      [7:0]        rdData
);

	logic [7:0] mem [1 << ADDR_W];

	always_ff @(posedge clk_sys)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
		rdData <= mem[rdAddr];
	end

endmodule : sssc_file_ram

`default_nettype wire

//--- verification/sssc_core_monitor.sv
// Bus-side checker for the program flow core.
`timescale 1ns/1ps
`default_nettype none
`include "sssc_params.svh"

module sssc_core_monitor
	import sssc_pkg::*;
#(
	parameter int ADDR_W = 8
)(
	input wire logic              clk_sys,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready
);

	// Indices are held from the address handshake until the answer.
	logic [5:0] rdIdx;
	logic [5:0] wrIdx;

	function automatic logic isMapped(input logic [5:0] idx);
		return idx inside {[`SSSC_IDX_PCL:`SSSC_IDX_INDPTR],
			[`SSSC_IDX_ISSUE:`SSSC_IDX_FLAGS]};
	endfunction : isMapped

	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
			rdIdx <= 6'h00;
		else if (s_axi_arvalid && s_axi_arready)
			rdIdx <= s_axi_araddr[7:2];

	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
			wrIdx <= 6'h00;
		else if (s_axi_awvalid && s_axi_awready)
			wrIdx <= s_axi_awaddr[7:2];

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_arTake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wrTake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rWait;
		s_axi_rvalid && !s_axi_rready;
	endsequence

	property p_bHold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bHold: assert property (p_bHold) else $error("write answer dropped");

	property p_rHold;
		s_rWait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_rHold: assert property (p_rHold) else $error("read answer dropped");

	property p_rAnswer;
		s_arTake |=> s_axi_rvalid;
	endproperty
	a_rAnswer: assert property (p_rAnswer) else $error("read answer late");

	property p_bAnswer;
		s_wrTake |-> ##[1:5] s_axi_bvalid;
	endproperty
	a_bAnswer: assert property (p_bAnswer) else $error("write answer late");

	property p_rRefuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rRefuse: assert property (p_rRefuse) else $error("read taken early");

	property p_rdUnmapped;
		s_axi_rvalid && !isMapped(rdIdx) |->
			s_axi_rresp == `SSSC_RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_rdUnmapped: assert property (p_rdUnmapped) else $error("bad read");

	property p_rdMapped;
		s_axi_rvalid && isMapped(rdIdx) |-> s_axi_rresp == `SSSC_RESP_OKAY;
	endproperty
	a_rdMapped: assert property (p_rdMapped) else $error("read refused");

	property p_wrUnmapped;
		s_axi_bvalid && !isMapped(wrIdx) |-> s_axi_bresp == `SSSC_RESP_SLVERR;
	endproperty
	a_wrUnmapped: assert property (p_wrUnmapped) else $error("bad write");

	property p_pcWidth;
		s_axi_rvalid && rdIdx == `SSSC_IDX_PCFULL |->
			s_axi_rdata[31:27] == 5'h0 && s_axi_rdata[15:11] == 5'h0;
	endproperty
	a_pcWidth: assert property (p_pcWidth) else $error("address too wide");

endmodule : sssc_core_monitor

bind sssc_core sssc_core_monitor #(.ADDR_W(ADDR_W)) i_sssc_core_monitor
(
	.clk_sys(clk_sys), .reset(reset),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

`default_nettype wire

//--- verification/sssc_core_tb_top.sv
// Register-level testbench for the program flow core.
`timescale 1ns/1ps
`default_nettype none
`include "sssc_params.svh"

module sssc_core_tb_top
	import sssc_pkg::*;
;
	localparam logic [7:0] A_PCL = {`SSSC_IDX_PCL, 2'b00};
	localparam logic [7:0] A_ST = {`SSSC_IDX_STATUS, 2'b00};
	localparam logic [7:0] A_IP = {`SSSC_IDX_INDPTR, 2'b00};
	localparam logic [7:0] A_ISS = {`SSSC_IDX_ISSUE, 2'b00};
	localparam logic [7:0] A_W = {`SSSC_IDX_WREG, 2'b00};
	localparam logic [7:0] A_PCF = {`SSSC_IDX_PCFULL, 2'b00};
	localparam logic [7:0] A_RTC = {`SSSC_IDX_RTC, 2'b00};
	localparam logic [7:0] A_FLG = {`SSSC_IDX_FLAGS, 2'b00};
	localparam logic [11:0] SK_OP [8] = '{12'h2E8, 12'h2E8, 12'h3E8,
		12'h3E8, 12'h608, 12'h608, 12'h7E8, 12'h7E8};
	localparam logic [7:0] SK_IN [8] = '{8'h01, 8'h02, 8'hFF, 8'h00,
		8'hFE, 8'h01, 8'h80, 8'h7F};

	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  awAddr = 8'h00;
	logic [7:0]  arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic [31:0] rData;
	logic [31:0] d;
	logic [1:0]  bResp;
	logic [1:0]  rResp;
	logic [1:0]  resp;
	logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
	logic        arValid = 1'b0, rReady = 1'b0;
	logic        awReady, wReady, bValid, arReady, rValid;
	int          nFail = 0;
	int          testsRun = 0;

	sssc_core i_sssc_core
	(
		.clk_sys(clk_sys), .reset(reset),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady)
	);

	always #5 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			nFail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Address and data are offered together; each drops once taken.
	// The answer is made to wait a cycle so that its hold is exercised.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aDone;
		logic wDone;
		@(posedge clk_sys);
		awAddr <= a;
		wData <= v;
		awValid <= 1'b1;
		wValid <= 1'b1;
		aDone = 1'b0;
		wDone = 1'b0;
		while (!(aDone && wDone))
		begin
			@(posedge clk_sys);
			aDone = aDone | awReady;
			wDone = wDone | wReady;
			awValid <= !aDone;
			wValid <= !wDone;
		end
		do @(posedge clk_sys); while (!bValid);
		bReady <= 1'b1;
		do @(posedge clk_sys); while (!bValid);
		bReady <= 1'b0;
		resp = bResp;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		arAddr <= a;
		arValid <= 1'b1;
		do @(posedge clk_sys); while (!arReady);
		arValid <= 1'b0;
		do @(posedge clk_sys); while (!rValid);
		rReady <= 1'b1;
		do @(posedge clk_sys); while (!rValid);
		rReady <= 1'b0;
		v = rData;
		resp = rResp;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(v, e);
	endtask : rdc

	task automatic ex(input logic [11:0] op);
		wr(A_ISS, {20'h0, op});
	endtask : ex

	// File register 08h is loaded through W, since no plain move exists.
	task automatic setf(input logic [7:0] v);
		ex(12'hC00);
		ex(12'h168);
		ex({4'hC, v});
		ex(12'h128);
	endtask : setf

	task automatic getf(input logic [7:0] e);
		ex(12'hC00);
		ex(12'h108);
		rdc(A_W, {24'h0, e});
	endtask : getf

	task automatic skipCase(input logic [11:0] op, input logic [7:0] v,
		input logic taken);
		setf(v);
		ex(12'hC00);
		ex(op);
		ex(12'hC5A);
		rdc(A_W, taken ? 32'h00 : 32'h5A);
	endtask : skipCase

	task automatic skipRun(input int nPg);
		logic [7:0] cnt;
		rd(A_FLG, d);
		cnt = d[15:8];
		setf(8'h01);
		ex(12'hC00);
		ex(12'h2E8);
		rd(A_FLG, d);
		chk(d[1], 1'b1);
		for (int i = 0; i < nPg; i++)
			ex(i[0] ? 12'h01F : 12'h013);
		ex(12'hC5A);
		rdc(A_W, 32'h00);
		rd(A_FLG, d);
		chk({d[15:8], d[1]}, {8'(cnt + nPg + 1), 1'b0});
	endtask : skipRun

	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tallyAndFinish

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		nFail++;
		tallyAndFinish();
	end

	initial
	begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		rdc(A_ST, 32'h18);
		rdc(A_IP, 32'h00);
		rdc(A_PCF, 32'h00);
		wr(A_ST, 32'h07);
		chk(resp, `SSSC_RESP_OKAY);
		rdc(A_ST, 32'h1F);
		wr(A_ST, 32'hFF);
		rdc(A_ST, 32'hFF);
		wr(A_ST, 32'h00);
		rdc(8'h7C, 32'h00);
		chk(resp, `SSSC_RESP_SLVERR);
		wr(8'h7C, 32'h55);
		chk(resp, `SSSC_RESP_SLVERR);
		wr(A_PCL, 32'h10);
		ex(12'h011);
		rdc(A_ST, 32'h38);
		ex(12'h016);
		rdc(A_ST, 32'h38);
		rd(A_FLG, d);
		chk(d[0], 1'b1);
		wr(A_FLG, 32'h01);
		rd(A_FLG, d);
		chk(d[0], 1'b0);
		wr(A_PCL, 32'h20);
		ex(12'h955);
		rdc(A_PCF, 32'h0221_0255);
		ex(12'hB23);
		rdc(A_PCF, 32'h0221_0323);
		wr(A_W, 32'h11);
		ex(12'h87E);
		rdc(A_PCF, 32'h0000_0221);
		rdc(A_W, 32'h7E);
		wr(A_ST, 32'h00);
		for (int i = 1; i <= 9; i++)
		begin
			wr(A_PCL, 32'(i * 16));
			ex(12'h900);
		end
		wr(A_W, 32'h3C);
		for (int j = 0; j < 9; j++)
		begin
			ex(12'h00C);
			rd(A_PCF, d);
			chk(d[10:0], (j < 8) ? 11'((9 - j) * 16 + 1) : 11'h021);
		end
		rdc(A_W, 32'h3C);
		wr(A_ST, 32'h40);
		wr(A_PCL, 32'h30);
		ex(12'h900);
		ex(12'h010);
		ex(12'h00D);
		rd(A_ST, d);
		chk(d[7:5], 3'h2);
		rd(A_PCF, d);
		chk(d[10:0], 11'h431);
		wr(A_W, 32'h05);
		wr(A_RTC, 32'h10);
		ex(12'h900);
		ex(12'h00F);
		rdc(A_RTC, 32'h15);
		wr(A_PCL, 32'h70);
		ex(12'h900);
		ex(12'h00E);
		rd(A_PCF, d);
		chk(d[10:0], 11'h471);
		ex(12'hC00);
		ex(12'h102);
		rdc(A_W, 32'h72);
		setf(8'h3C);
		ex(12'hC0F);
		ex(12'h188);
		rdc(A_W, 32'h33);
		wr(A_IP, 32'h08);
		ex(12'h100);
		rdc(A_W, 32'h3F);
		ex(12'hC00);
		ex(12'h104);
		rdc(A_W, 32'h08);
		wr(A_ST, 32'h00);
		setf(8'h81);
		ex(12'h368);
		rd(A_ST, d);
		chk(d[0], 1'b1);
		getf(8'h02);
		ex(12'h328);
		rd(A_ST, d);
		chk(d[0], 1'b0);
		getf(8'h81);
		ex(12'h268);
		getf(8'h7E);
		ex(12'hFFF);
		rdc(A_W, 32'h81);
		ex(12'h388);
		rdc(A_W, 32'hE7);
		for (int k = 0; k < 8; k++)
			skipCase(SK_OP[k], SK_IN[k], k[0] == 1'b0);
		skipRun(1);
		skipRun(3);
		rdc(A_IP, 32'h08);
		rd(A_ST, d);
		chk(d[7:5], 3'h0);
		ex(12'h01A);
		rdc(A_IP, 32'h48);
		tallyAndFinish();
	end

endmodule : sssc_core_tb_top

`default_nettype wire
